// [design/rwcm_top.sv]
// Reset sequencer, watchdog and clock monitor with a Wishbone register slave
`include "rwcm_params.svh"
module rwcm_top #(
    parameter int POR_CYCLES = `RWCM_POR_CYC,
    parameter int CM_CYCLES = `RWCM_CM_CYC,
    parameter int WDG_PRE_LOG2 = `RWCM_WDG_PRE
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_osc_active,
    input wire logic i_e_clk,
    input wire logic i_special_mode,
    input wire logic i_reset_pin_in,
    output logic o_reset_pin_out,
    output logic o_reset_pin_oe,
    output logic o_cpu_reset,
    output logic [15:0] o_vector_addr,
    output logic o_irq_edge_sel,
    output logic o_adc_power_up,
    output logic o_adc_clock_sel,
    output logic o_osc_startup_delay_en,
    input wire rwcm_pkg::rwcm_wb_req_t i_wb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);
    localparam int WDG_W = WDG_PRE_LOG2 + 6;
    localparam int CM_W = $clog2(CM_CYCLES + 1);

    rwcm_pkg::rwcm_state_t state;
    rwcm_pkg::rwcm_state_t next_state;
    rwcm_pkg::rwcm_cause_t cause;
    rwcm_pkg::rwcm_cause_t next_cause;
    logic [11:0] seq_cnt;
    logic [11:0] next_seq_cnt;
    logic e_prev;
    logic [CM_W-1:0] cm_cnt;
    logic [WDG_W-1:0] wdg_cnt;
    logic svc_armed;
    logic [1:0] rate;
    logic clk_monitor_en;
    logic osc_startup_delay_en;
    logic irq_edge_sel;
    logic adc_power_up;
    logic adc_clock_sel;
    logic once_done;
    logic [6:0] win_cnt;
    logic disable_resets_bit;
    logic mode_special;
    logic cfg_wdg_dis;
    logic wdg_dis_act;

    // E clock is sampled as a level; one rising edge per E cycle
    wire logic e_tick = i_e_clk & ~e_prev;
    // Monitor timeout also serves as a substitute tick so a reset
    // sequence can finish while the E clock is stopped
    wire logic cm_to = cm_cnt == CM_W'(CM_CYCLES - 1);
    wire logic adv = e_tick | cm_to;
    wire logic in_run = state == rwcm_pkg::ST_RUN;
    wire logic rst_all = ~i_rst_n | ~in_run;
    wire logic pin_high = i_reset_pin_in;

    // Bus decode
    wire logic wb_req = i_wb.cyc & i_wb.stb & ~o_wb_ack;
    wire logic wb_wr = wb_req & i_wb.we & i_wb.sel[0];
    wire logic hit_setup = i_wb.adr == `RWCM_OFS_SETUP;
    wire logic hit_svc = i_wb.adr == `RWCM_OFS_SERVICE;
    wire logic hit_test = i_wb.adr == `RWCM_OFS_TEST;
    wire logic hit_cfg = i_wb.adr == `RWCM_OFS_CONFIG;
    wire logic hit_stat = i_wb.adr == `RWCM_OFS_STATUS;
    wire logic [7:0] wdat = i_wb.dat[7:0];

    wire logic win_open = win_cnt != 7'(`RWCM_WR_WINDOW);
    wire logic once_ok = mode_special | (win_open & ~once_done); // [RL10]

    wire logic wdg_en = ~wdg_dis_act & ~(mode_special & disable_resets_bit); // [RL8] [RL20]

    // Timeout span is 2^(pre + 2*rate): divide by 1, 4, 16 or 64
    wire logic [WDG_W:0] wdg_span = {{WDG_W{1'b0}}, 1'b1} << (WDG_PRE_LOG2 + 2 * int'(rate)); // [RL9]
    wire logic [WDG_W:0] wdg_last = wdg_span - 1'b1;
    wire logic wdg_at_last = {1'b0, wdg_cnt} == wdg_last;
    // Counting only on E edges means a stopped clock freezes it
    wire logic wdg_fire = e_tick & wdg_at_last & wdg_en & in_run; // [RL12] [RL15]

    wire logic svc_arm = wb_wr & hit_svc & (wdat == `RWCM_SVC_ARM);
    wire logic svc_clr = wb_wr & hit_svc & (wdat == `RWCM_SVC_CLR) & svc_armed;

    // Stop mode halts the E clock, so an enabled monitor fires here too
    wire logic cm_fail = cm_to & clk_monitor_en & in_run; // [RL13] [RL16]

    wire logic [7:0] setup_rd = {adc_power_up, adc_clock_sel, irq_edge_sel, osc_startup_delay_en, clk_monitor_en,
        1'b0, rate};
    wire logic [7:0] test_rd = 8'(disable_resets_bit) << `RWCM_B_DISABLE_RESETS;
    wire logic [7:0] cfg_rd = 8'(cfg_wdg_dis) << `RWCM_B_WDG_DIS;
    wire logic [7:0] stat_rd = (8'(cause) << `RWCM_B_ST_CAUSE_LO)
        | (8'(mode_special) << `RWCM_B_ST_SPECIAL)
        | (8'(wdg_en) << `RWCM_B_ST_WDG_EN)
        | (8'(svc_armed) << `RWCM_B_ST_ARMED);
    // Service register is write-only and reads zero; unmapped reads zero
    wire logic [7:0] rd_byte = hit_setup ? setup_rd
        : hit_test ? test_rd
        : hit_cfg ? cfg_rd
        : hit_stat ? stat_rd
        : 8'h00;

    wire logic [15:0] vec_norm = (cause == rwcm_pkg::CAUSE_CM) ? `RWCM_VEC_N_CM
        : (cause == rwcm_pkg::CAUSE_WDG) ? `RWCM_VEC_N_WDG
        : `RWCM_VEC_N_RST; // [RL5]
    wire logic [15:0] vec_spec = (cause == rwcm_pkg::CAUSE_CM) ? `RWCM_VEC_S_CM
        : (cause == rwcm_pkg::CAUSE_WDG) ? `RWCM_VEC_S_WDG
        : `RWCM_VEC_S_RST; // [RL5]
    wire logic [15:0] vec_sel = mode_special ? vec_spec : vec_norm; // [RL19]

    always_comb begin
        next_state = state;
        next_cause = cause;
        next_seq_cnt = seq_cnt;
        unique case (state)
            rwcm_pkg::ST_POR: begin
                next_cause = rwcm_pkg::CAUSE_POR;
                if (adv & i_osc_active) begin
                    if (seq_cnt == 12'(POR_CYCLES - 1)) begin // [RL1]
                        next_state = rwcm_pkg::ST_PIN_WAIT;
                        next_seq_cnt = 12'h000;
                    end else begin
                        next_seq_cnt = seq_cnt + 12'h001;
                    end
                end
            end
            rwcm_pkg::ST_DRIVE: begin
                if (adv) begin
                    if (seq_cnt == 12'(`RWCM_DRIVE_CYC - 1)) begin // [RL3]
                        next_state = rwcm_pkg::ST_SETTLE;
                        next_seq_cnt = 12'h000;
                    end else begin
                        next_seq_cnt = seq_cnt + 12'h001;
                    end
                end
            end
            rwcm_pkg::ST_SETTLE: begin
                if (adv) begin
                    if (seq_cnt == 12'(`RWCM_SETTLE_CYC - 1)) begin // [RL4]
                        next_seq_cnt = 12'h000;
                        if (pin_high) begin
                            next_state = rwcm_pkg::ST_RUN;
                        end else begin
                            next_cause = rwcm_pkg::CAUSE_PIN;
                            next_state = rwcm_pkg::ST_PIN_WAIT;
                        end
                    end else begin
                        next_seq_cnt = seq_cnt + 12'h001;
                    end
                end
            end
            rwcm_pkg::ST_PIN_WAIT: begin
                if (pin_high) begin // [RL2]
                    next_state = rwcm_pkg::ST_RUN;
                end
            end
            rwcm_pkg::ST_RUN: begin
                // Pin outranks the monitor, which outranks the watchdog
                if (~pin_high) begin
                    next_cause = rwcm_pkg::CAUSE_PIN;
                    next_state = rwcm_pkg::ST_DRIVE;
                end else if (cm_fail) begin
                    next_cause = rwcm_pkg::CAUSE_CM;
                    next_state = rwcm_pkg::ST_DRIVE;
                end else if (wdg_fire) begin
                    next_cause = rwcm_pkg::CAUSE_WDG;
                    next_state = rwcm_pkg::ST_DRIVE;
                end
                next_seq_cnt = 12'h000;
            end
            default: begin
                next_state = rwcm_pkg::ST_POR;
                next_seq_cnt = 12'h000;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            state <= rwcm_pkg::ST_POR;
            cause <= rwcm_pkg::CAUSE_POR;
            seq_cnt <= 12'h000;
        end else begin
            state <= next_state;
            cause <= next_cause;
            seq_cnt <= next_seq_cnt;
        end
    end

    // Next-value decode of the sequencer outputs
    wire logic next_pin_oe = next_state == rwcm_pkg::ST_DRIVE; // [RL3]
    wire logic next_cpu_reset = next_state != rwcm_pkg::ST_RUN; // [RL6]
    // Vector only moves outside run, so it is steady as the CPU leaves reset
    wire logic vec_load = ~in_run;

    // Pin is only ever pulled low; the outside pull-up gives the high level
    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            o_reset_pin_out <= 1'h0;
            o_reset_pin_oe <= 1'h0;
        end else begin
            o_reset_pin_out <= 1'h0;
            o_reset_pin_oe <= next_pin_oe; // [RL3]
        end
    end

    // Taken from the next state so the CPU leaves reset together with it
    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            o_cpu_reset <= 1'h1;
        end else begin
            o_cpu_reset <= next_cpu_reset; // [RL6]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            o_vector_addr <= `RWCM_VEC_N_RST;
        end else if (vec_load) begin
            o_vector_addr <= vec_sel; // [RL6]
        end
    end

    // Clock monitor delay counter, restarted by every E edge
    wire logic cm_restart = e_tick | cm_to;

    // Edge memory follows the pin in reset too, so release shows no false edge
    always_ff @(posedge i_core_clk) begin
        e_prev <= i_e_clk;
    end

    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            cm_cnt <= '0;
        end else if (cm_restart) begin
            cm_cnt <= '0; // [RL22] [RL14]
        end else begin
            cm_cnt <= cm_cnt + 1'b1;
        end
    end

    // Watchdog counter and service sequence
    wire logic [WDG_W-1:0] wdg_step = wdg_at_last ? '0 : wdg_cnt + 1'b1;

    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            wdg_cnt <= '0; // [RL21]
        end else if (svc_clr) begin
            wdg_cnt <= '0; // [RL11]
        end else if (e_tick) begin
            wdg_cnt <= wdg_step; // [RL15]
        end
    end

    // Stray values leave the arm alone; a clear without arm does nothing
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            svc_armed <= 1'h0; // [RL21]
        end else if (svc_arm) begin
            svc_armed <= 1'h1; // [RL11]
        end else if (svc_clr) begin
            svc_armed <= 1'h0; // [RL11]
        end
    end

    // Write window after reset, counted in E cycles
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            win_cnt <= 7'h00;
        end else if (e_tick & win_open) begin
            win_cnt <= win_cnt + 7'h01;
        end
    end

    // Options register: monitor and converter bits take any write
    wire logic wr_setup = wb_wr & hit_setup;
    wire logic wr_once = wr_setup & once_ok; // [RL10]

    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            clk_monitor_en <= 1'h0; // [RL17]
        end else if (wr_setup) begin
            clk_monitor_en <= wdat[`RWCM_B_CLK_MON_EN]; // [RL17]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            adc_power_up <= 1'h0;
            adc_clock_sel <= 1'h0;
        end else if (wr_setup) begin
            adc_power_up <= wdat[`RWCM_B_ADC_POWER_UP];
            adc_clock_sel <= wdat[`RWCM_B_ADC_CLOCK_SEL];
        end
    end

    // Once-only fields outside special modes; a refused write is dropped with no error flagged
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            rate <= 2'h0; // [RL10]
            irq_edge_sel <= 1'h0;
            osc_startup_delay_en <= 1'h1;
            once_done <= 1'h0;
        end else if (wr_once) begin
            rate <= wdat[`RWCM_B_RATE_HI:`RWCM_B_RATE_LO]; // [RL10]
            irq_edge_sel <= wdat[`RWCM_B_IRQ_EDGE_SEL]; // [RL18]
            osc_startup_delay_en <= wdat[`RWCM_B_OSC_DELAY_EN];
            once_done <= 1'h1;
        end
    end

    // Mode strap follows its pin for as long as the block is in reset
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            mode_special <= i_special_mode;
        end
    end

    // Copied only in reset, so a changed setting waits for the next one
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            wdg_dis_act <= cfg_wdg_dis; // [RL7]
        end
    end

    // Disable-resets bit only matters in special modes
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            disable_resets_bit <= 1'h1; // [RL8]
        end else if (wb_wr & hit_test) begin
            disable_resets_bit <= wdat[`RWCM_B_DISABLE_RESETS]; // [RL8]
        end
    end

    // Nonvolatile setup copy survives system resets, only power-on clears it
    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            cfg_wdg_dis <= `RWCM_CFG_WDG_DIS_RST;
        end else if (wb_wr & hit_cfg) begin
            cfg_wdg_dis <= wdat[`RWCM_B_WDG_DIS]; // [RL7]
        end
    end

    // Wishbone answer one cycle after the request, dropped the next cycle
    wire logic [31:0] rd_word = wb_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            o_wb_ack <= 1'h0;
        end else begin
            o_wb_ack <= wb_req;
        end
    end

    // Data is zero outside an answer, so a stale read never lingers
    always_ff @(posedge i_core_clk) begin
        if (~i_rst_n) begin
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_dat <= rd_word;
        end
    end

    assign o_irq_edge_sel = irq_edge_sel;
    assign o_adc_power_up = adc_power_up;
    assign o_adc_clock_sel = adc_clock_sel;
    assign o_osc_startup_delay_en = osc_startup_delay_en;
endmodule : rwcm_top

// [design/rwcm_params.svh]
// Constants for the reset, watchdog and clock monitor block
// Function
// [RL1] After power-on, hold reset 4064 E cycles once the oscillator runs.
// [RL2] If the reset pin is low after that delay, stay in reset until high.
// [RL3] On any sensed reset, drive the reset pin low four E cycles, then release.
// [RL4] Sample the pin two E cycles after release: low external, high internal.
// [RL5] Power-on and pin share a vector; watchdog and monitor each own one.
// [RL6] Reset aborts execution, reloads the vector and restores control bits.
// [RL7] Watchdog enable follows the nonvolatile disable bit, applied at next reset.
// [RL8] Special modes start with watchdog resets inhibited; software may clear that.
// [RL9] Watchdog counts E divided by 2^15, then by 1, 4, 16 or 64.
// [RL10] Rate resets to 0; normal modes allow one write in 64 cycles.
// [RL11] Software writes 0x55 then 0xAA to the service register before timeout.
// [RL12] An enabled watchdog that expires unserviced starts a system reset.
// [RL13] An enabled monitor seeing no clock edge within its delay resets.
// [RL14] Below 10 kHz is a failure; 200 kHz or above never is.
// [RL15] The watchdog stops whenever the E clock stops.
// [RL16] Stop mode with the monitor enabled causes a reset.
// [RL17] Monitor enable is read/write any time and cleared by reset.
// [RL18] An option bit selects level (0) or edge (1) interrupt sensing.
// [RL19] Vectors FFFE, FFFC, FFFA in normal modes; BFxx in special modes.
// [RL20] Disable bit 0 allows watchdog reset on timeout, 1 suppresses it.
// [RL21] Any reset clears counter and arm; other written values keep arm.
// [RL22] Monitor delay is a counter on a free clock with a timeout parameter.
`ifndef RWCM_PARAMS_SVH
`define RWCM_PARAMS_SVH
`define RWCM_OFS_SETUP 8'h00
`define RWCM_OFS_SERVICE 8'h04
`define RWCM_OFS_TEST 8'h08
`define RWCM_OFS_CONFIG 8'h0C
`define RWCM_OFS_STATUS 8'h10
`define RWCM_B_ADC_POWER_UP 7
`define RWCM_B_ADC_CLOCK_SEL 6
`define RWCM_B_IRQ_EDGE_SEL 5
`define RWCM_B_OSC_DELAY_EN 4
`define RWCM_B_CLK_MON_EN 3
`define RWCM_B_RATE_HI 1
`define RWCM_B_RATE_LO 0
`define RWCM_B_DISABLE_RESETS 0
`define RWCM_B_WDG_DIS 0
`define RWCM_B_ST_CAUSE_LO 0
`define RWCM_B_ST_SPECIAL 2
`define RWCM_B_ST_WDG_EN 3
`define RWCM_B_ST_ARMED 4
`define RWCM_SVC_ARM 8'h55
`define RWCM_SVC_CLR 8'hAA
`define RWCM_CFG_WDG_DIS_RST 1'h0
`define RWCM_POR_CYC 4064
`define RWCM_DRIVE_CYC 4
`define RWCM_SETTLE_CYC 2
`define RWCM_WR_WINDOW 64
`define RWCM_WDG_PRE 15
`define RWCM_CLK_NS 10
`define RWCM_CM_DELAY_NS 20000
`define RWCM_CM_CYC (`RWCM_CM_DELAY_NS / `RWCM_CLK_NS)
`define RWCM_VEC_N_RST 16'hFFFE
`define RWCM_VEC_N_CM 16'hFFFC
`define RWCM_VEC_N_WDG 16'hFFFA
`define RWCM_VEC_S_RST 16'hBFFE
`define RWCM_VEC_S_CM 16'hBFFC
`define RWCM_VEC_S_WDG 16'hBFFA
`endif

// [design/rwcm_pkg.sv]
// Types shared by the reset, watchdog and clock monitor block
package rwcm_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_DRIVE = 3'h1,
        ST_SETTLE = 3'h2,
        ST_PIN_WAIT = 3'h3,
        ST_RUN = 3'h4
    } rwcm_state_t;
    typedef enum logic [1:0] {
        CAUSE_POR = 2'h0,
        CAUSE_PIN = 2'h1,
        CAUSE_CM = 2'h2,
        CAUSE_WDG = 2'h3
    } rwcm_cause_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rwcm_wb_req_t;
endpackage : rwcm_pkg

// [verif/rwcm_rst_circuit.sv]
// Model of the external reset circuit and voltage detector on the reset pin
module rwcm_rst_circuit (
    input wire logic i_drv_oe,
    input wire logic i_drv_out,
    input wire logic i_ext_hold,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up wins unless the device or the detector pulls low, so a released pin reads high
    assign o_pin = !((i_drv_oe && !i_drv_out) || i_ext_hold);
endmodule : rwcm_rst_circuit

// [verif/rwcm_checker.sv]
// Port checks for the reset, watchdog and clock monitor block
module rwcm_checker #(
    parameter int POR_CYCLES = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_osc_active,
    input wire logic i_e_clk,
    input wire logic i_special_mode,
    input wire logic i_reset_pin_in,
    input wire logic o_reset_pin_out,
    input wire logic o_reset_pin_oe,
    input wire logic o_cpu_reset,
    input wire logic [15:0] o_vector_addr,
    input wire rwcm_pkg::rwcm_wb_req_t i_wb,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic e_prev;
    logic [2:0] drive_cnt;
    logic [2:0] settle_cnt;
    logic [15:0] por_cnt;
    wire logic e_rise = i_e_clk && !e_prev;
    wire logic settle_inc = e_rise && o_cpu_reset && settle_cnt != 3'h7;
    // Counts E edges per phase; saturation keeps long pin waits from wrapping
    always_ff @(posedge i_core_clk) begin
        e_prev <= i_e_clk;
        if (!i_rst_n) begin
            drive_cnt <= 3'h0;
            settle_cnt <= 3'h0;
            por_cnt <= 16'h0000;
        end else begin
            drive_cnt <= o_reset_pin_oe ? drive_cnt + 3'(e_rise) : 3'h0;
            settle_cnt <= o_reset_pin_oe ? 3'h0 : settle_cnt + 3'(settle_inc);
            if (i_osc_active && e_rise && o_cpu_reset && por_cnt != 16'hFFFF) begin
                por_cnt <= por_cnt + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_taken;
        i_wb.cyc && i_wb.stb && !o_wb_ack;
    endsequence
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    a_ack_pulse: assert property (s_taken |=> s_ack_pulse) else $error("bus ack not one cycle");
    a_drive_low: assert property (o_reset_pin_oe |-> !o_reset_pin_out && o_cpu_reset) else $error("pin drive");
    a_drive_len: assert property ($fell(o_reset_pin_oe) |-> drive_cnt == 3'h4) else $error("drive length");
    a_settle_len: assert property ($fell(o_cpu_reset) |-> settle_cnt >= 3'h2) else $error("settle length");
    a_por_len: assert property ($fell(o_cpu_reset) |-> por_cnt >= 16'(POR_CYCLES)) else $error("por delay");
    a_pin_high: assert property ($fell(o_cpu_reset) |-> $past(i_reset_pin_in)) else $error("left reset, pin low");
    a_vec_sel: assert property ($fell(o_cpu_reset) |-> o_vector_addr[7:0] inside {8'hFE, 8'hFC, 8'hFA}
        && o_vector_addr[15:8] == (i_special_mode ? 8'hBF : 8'hFF)) else $error("vector");
    a_pin_sense: assert property (!o_cpu_reset && !o_reset_pin_oe && !i_reset_pin_in |-> ##[1:2] o_reset_pin_oe)
        else $error("pin low not answered");
endmodule : rwcm_checker

// [verif/rwcm_top_tb_top.sv]
// Self-checking bench for the reset, watchdog and clock monitor block
module rwcm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POR_N = 8;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic osc = 1'b0;
    logic e_clk = 1'b0;
    logic e_run = 1'b1;
    logic [3:0] e_div = 4'h0;
    logic special = 1'b0;
    logic hold = 1'b1;
    wire logic pin;
    rwcm_pkg::rwcm_wb_req_t wb = '0;
    logic pin_out, pin_oe, cpu_reset, irq_edge, wb_ack, adc_pu, adc_cs, dly_en;
    logic [15:0] vec;
    logic [31:0] wb_dat, rd;
    logic [31:0] seed = 32'h00010491;
    int n_mismatch = 0;
    int total_checks = 0;
    initial forever #5 i_core_clk = ~i_core_clk;
    // E period of 20 core cycles stays well inside the monitor delay
    always @(posedge i_core_clk) begin
        if (e_run) begin
            e_div <= (e_div == 4'h9) ? 4'h0 : e_div + 4'h1;
            if (e_div == 4'h9) e_clk <= ~e_clk;
        end
    end
    rwcm_rst_circuit u_ext (.i_drv_oe(pin_oe), .i_drv_out(pin_out), .i_ext_hold(hold), .o_pin(pin));
    rwcm_top #(.POR_CYCLES(POR_N), .CM_CYCLES(50), .WDG_PRE_LOG2(3)) dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_osc_active(osc), .i_e_clk(e_clk),
        .i_special_mode(special), .i_reset_pin_in(pin), .o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe),
        .o_cpu_reset(cpu_reset), .o_vector_addr(vec), .o_irq_edge_sel(irq_edge), .o_adc_power_up(adc_pu),
        .o_adc_clock_sel(adc_cs), .o_osc_startup_delay_en(dly_en), .i_wb(wb), .o_wb_dat(wb_dat),
        .o_wb_ack(wb_ack));
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function logic [15:0] exp_vec(input logic [1:0] cause, input logic sp);
        return {sp ? 8'hBF : 8'hFF, cause == 2'h3 ? 8'hFA : (cause == 2'h2 ? 8'hFC : 8'hFE)};
    endfunction : exp_vec
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task chk_bit(input string name, input logic exp, input logic got);
        chk(name, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit
    task tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : tick
    task wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge i_core_clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: {24'h000000, dat}};
        do begin
            @(posedge i_core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat;
        wb <= '0;
        if (n >= 50) chk("bus answer", 32'h1, 32'h0);
    endtask : wb_xfer
    // Waits for the pin drive to start, or for the CPU to leave reset
    task wait_for(input string name, input logic want_oe, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while ((want_oe ? pin_oe !== 1'b1 : cpu_reset !== 1'b0) && n < lim);
        if (n >= lim) chk(name, 32'h1, 32'h0);
    endtask : wait_for
    task finish_reset(input string name, input logic [1:0] cause);
        wait_for(name, 1'b0, 3000);
        chk(name, {16'h0000, exp_vec(cause, special)}, {16'h0000, vec});
        wb_xfer(1'b0, 8'h10, 8'h00);
        chk(name, {29'h0, special, cause}, {29'h0, rd[2:0]});
        $display("test %s done", name);
    endtask : finish_reset
    initial begin
        tick(20000);
        n_mismatch++;
        complete_run;
    end
    initial begin
        tick(4);
        i_rst_n <= 1'b1;
        tick(20);
        osc <= 1'b1;
        tick(POR_N * 40);
        chk_bit("held by pin", 1'b1, cpu_reset);
        hold <= 1'b0;
        finish_reset("power on", 2'h0);
        wb_xfer(1'b0, 8'h00, 8'h00);
        chk("option reset", 32'h10, rd);
        wb_xfer(1'b1, 8'h00, 8'h31);
        wb_xfer(1'b1, 8'h00, 8'h08);
        wb_xfer(1'b0, 8'h00, 8'h00);
        chk("option once", 32'h39, rd);
        chk_bit("irq edge", 1'b1, irq_edge);
        wb_xfer(1'b1, 8'h00, 8'h00);
        wb_xfer(1'b0, 8'h00, 8'h00);
        chk("monitor off", 32'h31, rd);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            wb_xfer(1'b1, {1'b1, seed[6:0]}, seed[15:8]);
            wb_xfer(1'b0, {1'b1, seed[6:0]}, 8'h00);
            chk("unmapped", 32'h0, rd);
        end
        for (int i = 0; i < 4; i++) begin
            tick(200);
            seed = xs(seed);
            wb_xfer(1'b1, 8'h04, 8'h55);
            wb_xfer(1'b1, 8'h04, (seed[7:0] == 8'hAA || seed[7:0] == 8'h55) ? 8'h00 : seed[7:0]);
            wb_xfer(1'b0, 8'h10, 8'h00);
            chk_bit("armed", 1'b1, rd[4]);
            wb_xfer(1'b1, 8'h04, 8'hAA);
            chk_bit("serviced", 1'b0, cpu_reset);
        end
        // A clear without arm must not restart the count
        wb_xfer(1'b1, 8'h04, 8'hAA);
        wait_for("wdg fire", 1'b1, 2000);
        finish_reset("watchdog", 2'h3);
        wb_xfer(1'b0, 8'h00, 8'h00);
        chk("rate cleared", 32'h10, rd);
        wb_xfer(1'b1, 8'h0C, 8'h01);
        wb_xfer(1'b0, 8'h10, 8'h00);
        chk_bit("disable pending", 1'b1, rd[3]);
        wait_for("wdg again", 1'b1, 400);
        finish_reset("watchdog two", 2'h3);
        wb_xfer(1'b0, 8'h10, 8'h00);
        chk_bit("disable applied", 1'b0, rd[3]);
        tick(400);
        chk_bit("no wdg reset", 1'b0, cpu_reset);
        hold <= 1'b1;
        wait_for("pin sense", 1'b1, 10);
        tick(300);
        chk_bit("pin held", 1'b1, cpu_reset);
        hold <= 1'b0;
        finish_reset("external pin", 2'h1);
        wb_xfer(1'b1, 8'h00, 8'hC8);
        chk("option pins", 32'h6, {29'h0, adc_pu, adc_cs, dly_en});
        tick(200);
        chk_bit("fast clock ok", 1'b0, cpu_reset);
        e_run <= 1'b0;
        wait_for("monitor fire", 1'b1, 200);
        e_run <= 1'b1;
        finish_reset("clock monitor", 2'h2);
        wb_xfer(1'b0, 8'h00, 8'h00);
        chk("monitor cleared", 32'h10, rd);
        chk_bit("irq level", 1'b0, irq_edge);
        chk("option pins reset", 32'h1, {29'h0, adc_pu, adc_cs, dly_en});
        tick(1400);
        wb_xfer(1'b1, 8'h00, 8'h23);
        wb_xfer(1'b0, 8'h00, 8'h00);
        chk("window closed", 32'h10, rd);
        special <= 1'b1;
        i_rst_n <= 1'b0;
        tick(4);
        i_rst_n <= 1'b1;
        finish_reset("special start", 2'h0);
        wb_xfer(1'b1, 8'h00, 8'h11);
        wb_xfer(1'b1, 8'h00, 8'h10);
        wb_xfer(1'b0, 8'h00, 8'h00);
        chk("special rate", 32'h10, rd);
        tick(400);
        chk_bit("inhibited", 1'b0, cpu_reset);
        wb_xfer(1'b1, 8'h08, 8'h00);
        wait_for("special wdg", 1'b1, 400);
        finish_reset("special watchdog", 2'h3);
        complete_run;
    end
endmodule : rwcm_top_tb_top
bind rwcm_top rwcm_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_osc_active(i_osc_active), .i_e_clk(i_e_clk),
    .i_special_mode(i_special_mode), .i_reset_pin_in(i_reset_pin_in), .o_reset_pin_out(o_reset_pin_out),
    .o_reset_pin_oe(o_reset_pin_oe), .o_cpu_reset(o_cpu_reset), .o_vector_addr(o_vector_addr),
    .i_wb(i_wb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));
